// [inc/per_regs.svh]
// What this block does
// - async events synchronized before synchronous subchannel
// - synchronizer delay two to three clock cycles
// - one event output pin per port
// - each user selects its channel by register
// - one generator per channel, register selected
// - after reset no channel has a generator
// - async events routed combinationally, between edges
// - async routing works with clock stopped
// - sync pulse lasts exactly one clock cycle
// - async pulse lasts one foreign clock cycle
// - sync level may last many cycles
// - async level from unclocked or foreign source
// - periodic taps divide by 64 through 8192
// - lookup table outputs are async levels
// - comparator output is async level
// - baud and host clocks: sync, two cycles
// - each channel has async and sync subchannel
// - six independent parallel channels
`ifndef PER_REGS_SVH
`define PER_REGS_SVH

// ==========================================================
// register map, byte addresses
`define PER_CHAN_BASE     8'h00
`define PER_CHAN_LAST     8'h14
`define PER_USER_BASE     8'h20
`define PER_USER_LAST     8'h3c
`define PER_PIN_BASE      8'h40
`define PER_PIN_LAST      8'h48
`define PER_STATUS        8'h50

// ==========================================================
// sizes and select codes
`define PER_NCHAN         6
`define PER_NUSER         8
`define PER_NPIN          3
`define PER_NASYNC        23
`define PER_NSYNC         8
`define PER_SEL_NONE      6'h00
`define PER_GEN_SYNC_BASE 6'h18
`define PER_GEN_LAST      6'h1f
`define PER_USEL_NONE     3'h0
`define PER_USEL_LAST     3'h6
`define PER_ZERO32        32'h0000_0000

`endif

// [inc/per_pkg.sv]
`include "per_regs.svh"

package per_pkg;

    // ======================================================
    // generator bundles
    // async generators, select codes 1..23 in reverse order, periodic_tap bit0 is code 1
    typedef struct packed {
        logic [1:0] rtc_pulse;           // overflow, compare
        logic [7:0] pin_level;           // port pins
        logic       comparator_out;      // follows comparator
        logic [3:0] lookup_table_output; // config dependent
        logic [7:0] periodic_tap;        // bit0 div_min .. bit7 div_max
    } per_async_gen_s;

    // clocked generators, select codes 24..31
    typedef struct packed {
        logic [2:0] timer_pulse;
        logic [2:0] adc_pulse;
        logic       spi_host_clock;
        logic       serial_baud_clock;
    } per_sync_gen_s;

    typedef enum {PER_REG_NONE, PER_REG_CHAN, PER_REG_USER,
                  PER_REG_PIN, PER_REG_STATUS} per_reg_e;

    typedef struct packed {
        per_reg_e   kind;
        logic [2:0] idx;
    } per_dec_s;

    // ======================================================
    // decoders shared by the datapath and its checks
    function automatic logic per_is_sync(logic [5:0] sel);
        per_is_sync = (sel >= `PER_GEN_SYNC_BASE) && (sel <= `PER_GEN_LAST);
    endfunction : per_is_sync

    function automatic logic per_pick_async(logic [22:0] v, logic [5:0] sel);
        per_pick_async = 1'b0;
        if (sel != `PER_SEL_NONE && sel < `PER_GEN_SYNC_BASE) begin
            per_pick_async = v[5'(sel - 6'h01)];
        end
    endfunction : per_pick_async

    function automatic logic per_pick_sync(logic [7:0] v, logic [5:0] sel);
        per_pick_sync = 1'b0;
        if (per_is_sync(sel)) begin
            per_pick_sync = v[3'(sel - `PER_GEN_SYNC_BASE)];
        end
    endfunction : per_pick_sync

    function automatic logic per_pick_chan(logic [5:0] v, logic [2:0] sel);
        per_pick_chan = 1'b0;
        if (sel != `PER_USEL_NONE && sel <= `PER_USEL_LAST) begin
            per_pick_chan = v[sel - 3'h1];
        end
    endfunction : per_pick_chan

    function automatic per_dec_s per_decode(logic [7:0] a);
        per_decode.kind = PER_REG_NONE;
        per_decode.idx  = a[4:2];
        if (a[1:0] == 2'h0) begin
            if (a <= `PER_CHAN_LAST) begin
                per_decode.kind = PER_REG_CHAN;
            end else if (a >= `PER_USER_BASE && a <= `PER_USER_LAST) begin
                per_decode.kind = PER_REG_USER;
            end else if (a >= `PER_PIN_BASE && a <= `PER_PIN_LAST) begin
                per_decode.kind = PER_REG_PIN;
            end else if (a == `PER_STATUS) begin
                per_decode.kind = PER_REG_STATUS;
            end
        end
    endfunction : per_decode

endpackage : per_pkg

// [hdl/per_sync.sv]
`timescale 1ns/1ns
`default_nettype none
`include "per_regs.svh"

// two front stages per channel; the router's own flop is the third
module per_sync import per_pkg::*; (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic [`PER_NCHAN-1:0]    async_in,
    output logic      [`PER_NCHAN-1:0]    meta_q
);

    logic [`PER_NCHAN-1:0] stage1;

    // ======================================================
    // front stages; stage1 feeds stage2 only
    genvar c;
    generate
        for (c = 0; c < `PER_NCHAN; c++) begin : g_ch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1[c] <= 1'b0;
                    meta_q[c] <= 1'b0;
                end else begin
                    stage1[c] <= async_in[c];
                    meta_q[c] <= stage1[c];
                end
            end
        end
    endgenerate

endmodule : per_sync

`default_nettype wire

// [hdl/per_amux.sv]
`timescale 1ns/1ns
`default_nettype none
`include "per_regs.svh"

// purely combinational so edges pass with the clock stopped
module per_amux import per_pkg::*; (
    input  wire logic [`PER_NASYNC-1:0] avec,
    input  wire logic [5:0]             chan_sel [`PER_NCHAN],
    output logic      [`PER_NCHAN-1:0]  chan_async
);

    // ======================================================
    // one generator per channel, none gives low
    genvar c;
    generate
        for (c = 0; c < `PER_NCHAN; c++) begin : g_ch
            assign chan_async[c] = per_pick_async(avec, chan_sel[c]);
        end
    endgenerate

endmodule : per_amux

`default_nettype wire

// [hdl/per_router.sv]
`timescale 1ns/1ns
`default_nettype none
`include "per_regs.svh"

module per_router import per_pkg::*; (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire per_async_gen_s         gen_async,
    input  wire per_sync_gen_s          gen_sync,
    output logic      [`PER_NCHAN-1:0]  chan_async_sub,
    output logic      [`PER_NCHAN-1:0]  chan_sync_sub,
    output logic      [`PER_NUSER-1:0]  user_async_evt,
    output logic      [`PER_NUSER-1:0]  user_sync_evt,
    output logic      [`PER_NPIN-1:0]   event_pin_output
);

    // ======================================================
    // state

    logic [5:0]              chan_sel [`PER_NCHAN];
    logic [2:0]              user_sel [`PER_NUSER];
    logic [2:0]              pin_sel  [`PER_NPIN];
    logic [`PER_NASYNC-1:0]  avec;
    logic [`PER_NSYNC-1:0]   svec;
    logic [`PER_NCHAN-1:0]   meta_q;
    per_dec_s                dec;
    logic                    wr_done;
    logic [31:0]             next_rdata;

    // ======================================================
    // generator bundles
    // taps, tables, comparator and pins are async levels,
    // rtc pulses async pulses of a foreign clock
    assign avec = gen_async;
    // baud and host clocks are clocked levels of two cycles
    assign svec = gen_sync;

    // ======================================================
    // async subchannels
    // no flop on this path so sleep without clock still routes
    per_amux u_amux (
        .avec       (avec),
        .chan_sel   (chan_sel),
        .chan_async (chan_async_sub)
    );

    // ======================================================
    // synchronizer front for async sources
    per_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (chan_async_sub),
        .meta_q   (meta_q)
    );

    // ======================================================
    // sync subchannels
    // clocked sources take one flop so a pulse stays one cycle;
    // async sources take the third synchronizer stage here,
    // giving two to three cycles from the event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_sync_sub <= '0;
        end else begin
            for (int c = 0; c < `PER_NCHAN; c++) begin
                if (chan_sel[c] == `PER_SEL_NONE) begin
                    chan_sync_sub[c] <= 1'b0;
                end else if (per_is_sync(chan_sel[c])) begin
                    chan_sync_sub[c] <= per_pick_sync(svec, chan_sel[c]);
                end else begin
                    chan_sync_sub[c] <= meta_q[c];
                end
            end
        end
    end

    // ======================================================
    // user multiplexers
    // async users see the channel between edges
    genvar u;
    generate
        for (u = 0; u < `PER_NUSER; u++) begin : g_user
            assign user_async_evt[u] =
                per_pick_chan(chan_async_sub, user_sel[u]);
        end
    endgenerate

    // sync users get a registered copy, one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_sync_evt <= '0;
        end else begin
            for (int i = 0; i < `PER_NUSER; i++) begin
                user_sync_evt[i] <=
                    per_pick_chan(chan_sync_sub, user_sel[i]);
            end
        end
    end

    // ======================================================
    // event pins, forwarded without detection
    genvar p;
    generate
        for (p = 0; p < `PER_NPIN; p++) begin : g_pin
            assign event_pin_output[p] =
                per_pick_chan(chan_async_sub, pin_sel[p]);
        end
    endgenerate

    // ======================================================
    // apb slave
    // one wait-free access: answer prepared in setup,
    // write taken on the completing edge only
    assign dec     = per_decode(paddr);
    assign wr_done = psel && penable && pready && pwrite;

    // read mux
    always_comb begin
        next_rdata = `PER_ZERO32;
        case (dec.kind)
            PER_REG_CHAN: begin
                next_rdata[5:0] = chan_sel[dec.idx];
            end
            PER_REG_USER: begin
                next_rdata[2:0] = user_sel[dec.idx];
            end
            PER_REG_PIN: begin
                next_rdata[2:0] = pin_sel[dec.idx[1:0]];
            end
            PER_REG_STATUS: begin
                // synced levels only; raw async would be unsafe to read
                next_rdata[`PER_NCHAN-1:0] = chan_sync_sub;
            end
            default: begin
                next_rdata = `PER_ZERO32;
            end
        endcase
    end

    // handshake and answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `PER_ZERO32;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= (dec.kind == PER_REG_NONE);
            prdata  <= pwrite ? `PER_ZERO32 : next_rdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `PER_ZERO32;
        end
    end

    // channel generator selects, cleared by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < `PER_NCHAN; c++) begin
                chan_sel[c] <= `PER_SEL_NONE;
            end
        end else if (wr_done && dec.kind == PER_REG_CHAN) begin
            chan_sel[dec.idx] <= pwdata[5:0];
        end
    end

    // user channel selects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `PER_NUSER; i++) begin
                user_sel[i] <= `PER_USEL_NONE;
            end
        end else if (wr_done && dec.kind == PER_REG_USER) begin
            user_sel[dec.idx] <= pwdata[2:0];
        end
    end

    // pin channel selects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `PER_NPIN; i++) begin
                pin_sel[i] <= `PER_USEL_NONE;
            end
        end else if (wr_done && dec.kind == PER_REG_PIN) begin
            pin_sel[dec.idx[1:0]] <= pwdata[2:0];
        end
    end

    // ======================================================
    // checks

    default clocking cb @(posedge pclk);
    endclocking

    default disable iff (!presetn);

    logic any_chan_sel;

    // helper: any channel connected
    always_comb begin
        any_chan_sel = 1'b0;
        for (int c = 0; c < `PER_NCHAN; c++) begin
            any_chan_sel = any_chan_sel | (chan_sel[c] != `PER_SEL_NONE);
        end
    end

    AST_RESET_UNCONNECTED: assert property (
        $rose(presetn) |-> !any_chan_sel
    ) else $error("channel connected right after reset");

    AST_CHAN_WRITE: assert property (
        (wr_done && dec.kind == PER_REG_CHAN && dec.idx == 3'h0)
        |=> chan_sel[0] == $past(pwdata[5:0])
    ) else $error("channel select write lost");

    AST_USER_MUX: assert property (
        $stable(user_sel[0])
        |=> user_sync_evt[0] == $past(per_pick_chan(chan_sync_sub, user_sel[0]))
    ) else $error("sync user does not follow its channel");

    AST_PIN_FWD: assert property (
        event_pin_output[0] == per_pick_chan(chan_async_sub, pin_sel[0])
    ) else $error("event pin does not follow its channel");

    AST_ASYNC_ROUTE: assert property (
        chan_async_sub[0] == per_pick_async(avec, chan_sel[0])
    ) else $error("async subchannel not routed from generator");

    // bus answer; masters may count on the single access cycle
    AST_APB_ANSWER: assert property (
        (psel && !penable) |=> pready
    ) else $error("access phase not answered at once");

    AST_APB_READY_PULSE: assert property (
        pready |=> !pready
    ) else $error("ready held past one cycle");

    AST_APB_UNMAPPED: assert property (
        (psel && !penable && dec.kind == PER_REG_NONE) |=> pslverr && pready
    ) else $error("unmapped access not flagged");

    AST_STATUS_READ: assert property (
        (psel && !penable && !pwrite && dec.kind == PER_REG_STATUS)
        |=> prdata[`PER_NCHAN-1:0] == $past(chan_sync_sub)
    ) else $error("status read does not show sync subchannels");

    AST_USER_ASYNC: assert property (
        user_async_evt[0] == per_pick_chan(chan_async_sub, user_sel[0])
    ) else $error("async user does not follow its channel");

    genvar k;
    generate
        for (k = 0; k < `PER_NCHAN; k++) begin : g_chk

            sequence s_async_hi;
                $stable(chan_sel[k]) && chan_sel[k] != `PER_SEL_NONE
                && !per_is_sync(chan_sel[k]) && chan_async_sub[k];
            endsequence

            sequence s_async_lo;
                $stable(chan_sel[k]) && !per_is_sync(chan_sel[k])
                && !chan_async_sub[k];
            endsequence

            sequence s_sync_hi;
                $stable(chan_sel[k]) && per_is_sync(chan_sel[k])
                && per_pick_sync(svec, chan_sel[k]);
            endsequence

            AST_NONE_QUIET: assert property (
                (chan_sel[k] == `PER_SEL_NONE) [*2]
                |-> !chan_async_sub[k] && !chan_sync_sub[k]
            ) else $error("unconnected channel not low");

            AST_SYNC_LATENCY: assert property (
                s_async_hi [*3] |=> chan_sync_sub[k]
            ) else $error("async event not synced within three cycles");

            AST_SYNC_EARLY: assert property (
                s_async_lo [*3] |=> !chan_sync_sub[k]
            ) else $error("sync subchannel ahead of synchronizer");

            AST_SYNC_PULSE: assert property (
                (per_is_sync(chan_sel[k]))
                |=> chan_sync_sub[k] == $past(per_pick_sync(svec, chan_sel[k]))
            ) else $error("clocked event not passed in one cycle");

            AST_LEVEL_HOLD: assert property (
                s_sync_hi [*3] |-> chan_sync_sub[k] ##1 chan_sync_sub[k]
            ) else $error("clocked level not held");

        end
    endgenerate

endmodule : per_router

`default_nettype wire

// [sim/per_gen_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// generating peripherals as seen from the router inputs
module per_gen_model import per_pkg::*; (
    input  wire logic           pclk,
    output var  per_async_gen_s gen_async,
    output var  per_sync_gen_s  gen_sync
);
    initial begin
        gen_async = '0;
        gen_sync  = '0;
    end

    // clocked sources: pulse when len is 1, level otherwise
    task automatic sync_drive(input logic [7:0] v, input int len);
        @(posedge pclk);
        gen_sync <= v;
        repeat (len) @(posedge pclk);
        gen_sync <= 8'h00;
    endtask : sync_drive

    // unclocked sources move between edges, never on one
    task automatic async_set(input logic [22:0] v);
        #13;
        gen_async = v;
    endtask : async_set

    // foreign clock pulse of 70 ns, longer than one pclk period
    task automatic async_pulse(input int n);
        #13;
        gen_async[n] = 1'b1;
        #70;
        gen_async[n] = 1'b0;
    endtask : async_pulse
endmodule : per_gen_model

`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top import per_pkg::*; ();
    logic           pclk    = 1'b0;
    logic           clk_run = 1'b1;
    logic           presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata;
    per_async_gen_s gen_async;
    per_sync_gen_s  gen_sync;
    logic [5:0]     chan_async_sub, chan_sync_sub, cs_q;
    logic [7:0]     user_async_evt, user_sync_evt, gs_q;
    logic [2:0]     event_pin_output;
    logic [15:0]    lfsr_q = 16'h0ec7;
    logic           mon_on = 1'b0;
    int             err_count = 0;
    int             comparisons = 0;
    int             csel [6];
    int             usel [8];
    int             pinsel [3];

    // ==========================================================
    // clock can be frozen to mimic a sleep mode
    always #25 if (clk_run) pclk = ~pclk;

    per_router u_per_router (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gen_async(gen_async), .gen_sync(gen_sync),
        .chan_async_sub(chan_async_sub), .chan_sync_sub(chan_sync_sub),
        .user_async_evt(user_async_evt), .user_sync_evt(user_sync_evt),
        .event_pin_output(event_pin_output));
    per_gen_model u_per_gen_model (.pclk(pclk), .gen_async(gen_async), .gen_sync(gen_sync));

    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction : rnd

    function automatic logic [22:0] r23();
        logic [31:0] t;
        t = {rnd(), rnd()};
        return t[22:0];
    endfunction : r23

    // one apb transfer; holds everything until pready is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) err_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        check(err, 1'b0);
        if (a < 8'h18) csel[a[4:2]] = d[5:0];
        else if (a < 8'h40) usel[a[4:2]] = d[2:0];
        else pinsel[a[3:2]] = d[2:0];
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(rd, exp);
        check(err, eerr);
    endtask : rd_chk

    // reference for async outputs; sync-coded channels are masked out
    task automatic check_async();
        logic [5:0]  ec, mc;
        logic [10:0] eu, mu;
        logic [22:0] ga;
        int          s;
        ga = gen_async;
        for (int c = 0; c < 6; c++) begin
            mc[c] = csel[c] < 24 || csel[c] > 31;
            ec[c] = csel[c] >= 1 && csel[c] <= 23 && ga[csel[c] - 1];
        end
        for (int i = 0; i < 11; i++) begin
            s = i < 8 ? usel[i] : pinsel[i - 8];
            mu[i] = s < 1 || s > 6 || mc[s - 1];
            eu[i] = s >= 1 && s <= 6 && ec[s - 1];
        end
        check(chan_async_sub & mc, ec & mc);
        check({event_pin_output, user_async_evt} & mu, eu & mu);
    endtask : check_async

    // status from the model; clocked sources are idle when it is read
    function automatic logic [31:0] exp_status();
        logic [31:0] e;
        e = 32'h0000_0000;
        for (int c = 0; c < 6; c++)
            e[c] = csel[c] >= 1 && csel[c] <= 23 && gen_async[csel[c] - 1];
        return e;
    endfunction : exp_status

    task automatic test_done(input string s);
        $display("test %s finished, mismatches so far %0d", s, err_count);
    endtask : test_done

    // ==========================================================
    // clocked paths compared mid-cycle against last edge's inputs
    always @(posedge pclk) begin
        gs_q <= gen_sync;
        cs_q <= chan_sync_sub;
    end

    always @(negedge pclk) begin
        if (mon_on) begin
            for (int c = 0; c < 6; c++) begin
                if (csel[c] < 1 || csel[c] > 23)
                    check(chan_sync_sub[c], csel[c] >= 24 && csel[c] <= 31 && gs_q[csel[c] - 24]);
            end
            for (int u = 0; u < 8; u++)
                check(user_sync_evt[u], usel[u] >= 1 && usel[u] <= 6 && cs_q[usel[u] - 1]);
        end
    end

    // watchdog, far beyond the fewer than one thousand cycles of the run
    initial begin
        #2_000_000;
        err_count++;
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] rd, d;
        logic        err;
        logic [22:0] v;
        logic [7:0]  a;
        int          c, n, k2;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        // every generator active through reset: nothing may leak out
        fork
            u_per_gen_model.sync_drive(8'hff, 30);
        join_none
        u_per_gen_model.async_set(23'h7f_ffff);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1 check({chan_async_sub, chan_sync_sub, user_async_evt, user_sync_evt, event_pin_output}, 0);
        for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), 0, 1'b0);
        test_done("reset");

        // random register contents, async outputs checked after each
        for (int r = 0; r < 2; r++) begin
            u_per_gen_model.async_set(r23());
            for (int i = 0; i < 17; i++) begin
                a = i < 6 ? 8'(i * 4) : i < 14 ? 8'(8'h20 + (i - 6) * 4) : 8'(8'h40 + (i - 14) * 4);
                d = {rnd(), rnd()};
                wr_reg(a, d);
                rd_chk(a, i < 6 ? d & 32'h3f : d & 32'h7, 1'b0);
                check_async();
            end
        end
        rd_chk(8'h18, 0, 1'b1);
        rd_chk(8'h4c, 0, 1'b1);
        rd_chk(8'h21, 0, 1'b1);
        apb(1'b1, 8'h50, 32'hffff_ffff, rd, err);
        check(err, 1'b0);
        test_done("registers");

        // every async code: generator first, then users and pins
        for (int k = 1; k <= 23; k++) begin
            c = k % 6;
            wr_reg(8'(c * 4), k);
            wr_reg(8'(8'h20 + c * 4), c + 1);
            wr_reg(8'(8'h40 + (c % 3) * 4), c + 1);
            v = r23() & ~(23'h1 << (k - 1));
            u_per_gen_model.async_set(v);
            repeat (4) @(posedge pclk);
            #1 check(chan_sync_sub[c], 0);
            u_per_gen_model.async_set(v | (23'h1 << (k - 1)));
            #1 check_async();
            n = 0;
            while (chan_sync_sub[c] !== 1'b1 && n < 6) begin
                @(posedge pclk);
                #1 n++;
            end
            check(n >= 2 && n <= 3, 1);
            rd_chk(8'h50, exp_status(), 1'b0);
        end
        // foreign clock pulse must still cross the synchronizer
        wr_reg(8'h00, 5);
        u_per_gen_model.async_set(0);
        repeat (4) @(posedge pclk);
        #1 u_per_gen_model.async_pulse(4);
        n = 0;
        while (chan_sync_sub[0] !== 1'b1 && n < 6) begin
            @(posedge pclk);
            #1 n++;
        end
        check(n <= 3, 1);
        test_done("async");

        // clock stopped: async routing must still follow sources
        @(negedge pclk);
        clk_run = 1'b0;
        for (int k = 0; k < 4; k++) begin
            u_per_gen_model.async_set(r23());
            #100 check_async();
        end
        clk_run = 1'b1;
        test_done("sleep");

        // clocked codes plus an empty and an out-of-range code
        wr_reg(8'h3c, 7);
        for (int k = 22; k <= 31; k++) begin
            mon_on = 1'b0;
            k2 = k < 24 ? (k == 22 ? 0 : 40) : k;
            c = k % 6;
            wr_reg(8'(c * 4), k2);
            wr_reg(8'(8'h20 + c * 4), c + 1);
            repeat (2) @(posedge pclk);
            mon_on = 1'b1;
            u_per_gen_model.sync_drive(k < 24 ? 8'hff : 8'h01 << (k - 24), k == 25 ? 4 : k < 25 ? 2 : 1);
            repeat (4) @(posedge pclk);
        end
        mon_on = 1'b0;
        test_done("sync");
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
